/* File: src/dmr36_pkg.sv */
// mode register bank constants and carriers for addresses 03h..06h
// assumes a command decoder upstream that delivers decoded mode register write/read strobes
package dmr36_pkg;

    localparam logic [5:0] ADDR_IO_CFG = 6'h03;
    localparam logic [5:0] ADDR_REFRESH = 6'h04;
    localparam logic [5:0] ADDR_MAKER = 6'h05;
    localparam logic [5:0] ADDR_REVISION = 6'h06;

    // io_drive_and_inversion_config field positions
    localparam int IO_PULLUP_BIT = 0;
    localparam int IO_POSTAMBLE_BIT = 1;
    localparam int IO_PROTECT_BIT = 2;
    localparam int IO_PULLDOWN_LSB = 3;
    localparam int IO_RD_INV_BIT = 6;
    localparam int IO_WR_INV_BIT = 7;

    // refresh_rate_and_thermal field positions
    localparam int RF_RATE_LSB = 0;
    localparam int RF_SRA_BIT = 3;
    localparam int RF_ENTRY_BIT = 4;
    localparam int RF_OFFSET_LSB = 5;
    localparam int RF_FLAG_BIT = 7;
    localparam logic [7:0] RF_WRITE_MASK = 8'h78;

    // reset values and reserved, future-use and derated codes
    localparam logic PULLUP_RESET = 1'b1;
    localparam logic POSTAMBLE_RESET = 1'b0;
    localparam logic [2:0] PULLDOWN_RESET = 3'h6;
    localparam logic [2:0] PULLDOWN_FUTURE = 3'h0;
    localparam logic [2:0] PULLDOWN_RESERVED = 3'h7;
    localparam logic [2:0] RATE_RESET = 3'h3;
    localparam logic [2:0] RATE_DERATED = 3'h6;
    localparam logic [1:0] OFFSET_RESERVED = 2'h3;

    typedef struct packed {
        logic write_inversion_en;
        logic read_inversion_en;
        logic [2:0] pulldown_strength;
        logic repair_protect;
        logic write_postamble_len;
        logic pullup_cal_point;
    } dmr36_io_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] data;
    } dmr36_cmd_t;

endpackage

/* File: src/dmr36_mode_regs.sv */
// mode register bank, addresses 03h to 06h, of one channel of a low-power dram die
// assumes commands arrive already decoded and synchronous to the dram clock;
// set-point selects come from the set-point control register elsewhere.
// Notes on behaviour
// - address 03h decodes to io config, 04h to refresh and thermal register
// - postamble bit: 0 gives half clock by default, 1 gives 1.5 clock
// - repair protection defaults off, is sticky once set, cleared only by power-on reset
// - while repair protection is on, writes of 1 to repair entry are refused
// - pull-down strength codes 001..110 select divide ratio, default 110
// - read and write inversion enables default off, enabled by 1
// - writes and reads of 03h reach only the write-set-point copy, except the repair protect bit, which is shared
// - device operates only from the operating-set-point copy
// - refresh-rate field reports required rate, default 011
// - refresh-rate bit 2 follows the above-85-degree indication
// - report code 110 whenever derating is needed
// - update flag sets on rate change since last read; read of 04h clears it
// - update flag is 0 at power-up
// - writes to 04h store only bits 6..3
// - self-refresh abort enable defaults off, exists only on dense dies
// - writing 1 to repair entry enters repair mode, 0 exits; default 0
// - thermal offset 00 none, 01 five, 10 ten degrees, 11 reserved
// - address 05h returns read-only maker identification
// - address 06h returns read-only first revision identifier
`timescale 1ns/1ps
`default_nettype none

module dmr36_mode_regs #(
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] REVISION_ID = 8'ha5, // arbitrary value
    parameter bit HAS_SELF_REFRESH_ABORT_EN = 1'b1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire dmr36_pkg::dmr36_cmd_t i_cmd,
    input wire logic i_write_set_point_sel,
    input wire logic i_operating_set_point_sel,
    input wire logic [2:0] i_sensor_rate,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output dmr36_pkg::dmr36_io_cfg_t o_io_cfg,
    output logic [2:0] o_refresh_rate,
    output logic o_self_refresh_abort_en,
    output logic o_repair_mode_entry,
    output logic [1:0] o_thermal_offset,
    output logic o_temp_update_flag
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic hit_io = i_cmd.addr == dmr36_pkg::ADDR_IO_CFG;
    wire logic hit_rf = i_cmd.addr == dmr36_pkg::ADDR_REFRESH;
    wire logic wr_io = i_cmd.wr && hit_io;
    wire logic wr_rf = i_cmd.wr && hit_rf;
    wire logic rd_rf = i_cmd.rd && hit_rf;

    // ----------------------------------------------------------------
    // io config, two set-point copies
    // ----------------------------------------------------------------
    // reset image of one copy; a constant, so the async reset loads no logic
    localparam dmr36_pkg::dmr36_io_cfg_t RESET_CFG = '{write_inversion_en: 1'b0,
                                                      read_inversion_en: 1'b0,
                                                      pulldown_strength: dmr36_pkg::PULLDOWN_RESET,
                                                      repair_protect: 1'b0,
                                                      write_postamble_len: dmr36_pkg::POSTAMBLE_RESET,
                                                      pullup_cal_point: dmr36_pkg::PULLUP_RESET};

    dmr36_pkg::dmr36_io_cfg_t copy_q [2];
    dmr36_pkg::dmr36_io_cfg_t wr_cfg;
    logic protect_q;

    // ----------------------------------------------------------------
    // write operand of 03h
    // ----------------------------------------------------------------

    // future-use and reserved strength codes keep the previous value
    wire logic [2:0] wr_pd = i_cmd.data[dmr36_pkg::IO_PULLDOWN_LSB +: 3];
    wire logic pd_bad = (wr_pd == dmr36_pkg::PULLDOWN_FUTURE) || (wr_pd == dmr36_pkg::PULLDOWN_RESERVED);
    wire dmr36_pkg::dmr36_io_cfg_t cur_wr_copy = copy_q[i_write_set_point_sel];
    assign wr_cfg.write_inversion_en = i_cmd.data[dmr36_pkg::IO_WR_INV_BIT];
    assign wr_cfg.read_inversion_en = i_cmd.data[dmr36_pkg::IO_RD_INV_BIT];
    assign wr_cfg.pulldown_strength = pd_bad ? cur_wr_copy.pulldown_strength : wr_pd;
    assign wr_cfg.repair_protect = i_cmd.data[dmr36_pkg::IO_PROTECT_BIT];
    assign wr_cfg.write_postamble_len = i_cmd.data[dmr36_pkg::IO_POSTAMBLE_BIT];
    assign wr_cfg.pullup_cal_point = i_cmd.data[dmr36_pkg::IO_PULLUP_BIT];

    // ----------------------------------------------------------------
    // set-point copy storage
    // ----------------------------------------------------------------
    // a write lands only in the copy named by the write select, so the
    // inactive set point can be prepared while the other one runs
    wire logic load_sp0 = wr_io && !i_write_set_point_sel;
    wire logic load_sp1 = wr_io && i_write_set_point_sel;

    dmr36_field_reg #(
        .WIDTH(8),
        .RESET_VALUE(RESET_CFG)
    ) copy_sp0_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(load_sp0),
        .i_d(wr_cfg),
        .o_q(copy_q[0])
    );

    dmr36_field_reg #(
        .WIDTH(8),
        .RESET_VALUE(RESET_CFG)
    ) copy_sp1_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(load_sp1),
        .i_d(wr_cfg),
        .o_q(copy_q[1])
    );

    // ----------------------------------------------------------------
    // sticky repair protection
    // ----------------------------------------------------------------
    // protection is one physical sticky bit shared by both copies; no write
    // path can load a zero, only the reset clears it
    wire logic protect_load = wr_io && wr_cfg.repair_protect;

    dmr36_field_reg #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) protect_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(protect_load),
        .i_d(1'b1),
        .o_q(protect_q)
    );

    // ----------------------------------------------------------------
    // operating copy
    // ----------------------------------------------------------------
    // the operating select switches the outputs at once; the copy the
    // write select names may differ, which is the point of two copies

    dmr36_pkg::dmr36_io_cfg_t op_cfg;
    always_comb begin
        op_cfg = copy_q[i_operating_set_point_sel];
        op_cfg.repair_protect = protect_q;
    end

    // ----------------------------------------------------------------
    // refresh and thermal register
    // ----------------------------------------------------------------
    logic [2:0] rate_q;
    logic sra_q;
    logic entry_q;
    logic [1:0] offset_q;
    logic flag_q;

    wire logic wr_entry = i_cmd.data[dmr36_pkg::RF_ENTRY_BIT];
    wire logic [1:0] wr_offset = i_cmd.data[dmr36_pkg::RF_OFFSET_LSB +: 2];
    wire logic entry_refused = wr_entry && protect_q;
    wire logic rate_changed = i_sensor_rate != rate_q;

    // ----------------------------------------------------------------
    // refresh rate and update flag
    // ----------------------------------------------------------------
    // the sensor code is taken every cycle; it is already the coded rate,
    // so bit 2 and the derated code pass straight through
    dmr36_field_reg #(
        .WIDTH(3),
        .RESET_VALUE(dmr36_pkg::RATE_RESET)
    ) rate_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(1'b1),
        .i_d(i_sensor_rate),
        .o_q(rate_q)
    );

    // a rate change in the same cycle as a read of 04h wins over the clear,
    // so a change is never lost between two polls
    wire logic flag_set = rate_changed;
    wire logic flag_clear = rd_rf;
    wire logic flag_load = flag_set || flag_clear;

    // the flag starts cleared; the rate itself only has a safe default
    dmr36_field_reg #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) flag_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(flag_load),
        .i_d(flag_set),
        .o_q(flag_q)
    );

    // ----------------------------------------------------------------
    // writable controls of 04h
    // ----------------------------------------------------------------
    // only bits 6..3 are stored; refresh-rate and flag bits are ignored
    wire logic sra_wr = HAS_SELF_REFRESH_ABORT_EN && i_cmd.data[dmr36_pkg::RF_SRA_BIT];
    wire logic entry_load = wr_rf && !entry_refused;
    wire logic offset_ok = wr_offset != dmr36_pkg::OFFSET_RESERVED;
    wire logic offset_load = wr_rf && offset_ok;

    dmr36_field_reg #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) sra_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(wr_rf),
        .i_d(sra_wr),
        .o_q(sra_q)
    );

    // a refused entry keeps the old state, a write of 0 still exits
    dmr36_field_reg #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) entry_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(entry_load),
        .i_d(wr_entry),
        .o_q(entry_q)
    );

    // the reserved offset code is refused rather than stored
    dmr36_field_reg #(
        .WIDTH(2),
        .RESET_VALUE(2'h0)
    ) offset_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(offset_load),
        .i_d(wr_offset),
        .o_q(offset_q)
    );

    // ----------------------------------------------------------------
    // identification
    // ----------------------------------------------------------------
    wire logic [7:0] maker_word = MAKER_ID;
    wire logic [7:0] revision_word = REVISION_ID;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire logic [7:0] rf_word = {flag_q, offset_q, entry_q, sra_q, rate_q};
    wire logic [7:0] io_word = {cur_wr_copy[7:3], protect_q, cur_wr_copy[1:0]};
    logic [7:0] rd_mux;
    always_comb begin
        case (i_cmd.addr)
            dmr36_pkg::ADDR_IO_CFG: rd_mux = io_word;
            dmr36_pkg::ADDR_REFRESH: rd_mux = rf_word;
            dmr36_pkg::ADDR_MAKER: rd_mux = maker_word;
            dmr36_pkg::ADDR_REVISION: rd_mux = revision_word;
            default: rd_mux = 8'h00;
        endcase
    end

    logic rd_valid_q;
    logic [7:0] rd_data_q;

    // the answer pulse follows every read strobe, mapped or not, so the
    // controller never waits on an unmapped address
    dmr36_field_reg #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) rd_valid_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(1'b1),
        .i_d(i_cmd.rd),
        .o_q(rd_valid_q)
    );

    // read data holds until the next read
    dmr36_field_reg #(
        .WIDTH(8),
        .RESET_VALUE(8'h00)
    ) rd_data_reg_i (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(i_cmd.rd),
        .i_d(rd_mux),
        .o_q(rd_data_q)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_rd_valid = rd_valid_q;
    assign o_rd_data = rd_data_q;
    assign o_io_cfg = op_cfg;
    assign o_refresh_rate = rate_q;
    assign o_self_refresh_abort_en = sra_q;
    assign o_repair_mode_entry = entry_q;
    assign o_thermal_offset = offset_q;
    assign o_temp_update_flag = flag_q;

endmodule

// ----------------------------------------------------------------
// loadable field register
// ----------------------------------------------------------------
// one field of the bank: loads on request, otherwise holds; the reset
// value is a parameter so every field keeps its own default
module dmr36_field_reg #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] field_q;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            field_q <= RESET_VALUE;
        end else if (i_load) begin
            field_q <= i_d;
        end
    end

    assign o_q = field_q;

endmodule

`default_nettype wire

/* File: tb/dmr36_monitor.sv */
// checker for the mode register bank, watching top-level ports only
// assumes it is bound onto dmr36_mode_regs from tb_top
`timescale 1ns/1ps
`default_nettype none
module dmr36_monitor #(
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [7:0] REVISION_ID = 8'ha5
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire dmr36_pkg::dmr36_cmd_t i_cmd,
    input wire logic [2:0] i_sensor_rate,
    input wire logic o_rd_valid,
    input wire logic [7:0] o_rd_data,
    input wire dmr36_pkg::dmr36_io_cfg_t o_io_cfg,
    input wire logic [2:0] o_refresh_rate,
    input wire logic o_repair_mode_entry,
    input wire logic [1:0] o_thermal_offset,
    input wire logic o_temp_update_flag
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd(a);
        i_cmd.rd && i_cmd.addr == a;
    endsequence
    sequence s_wr4;
        i_cmd.wr && i_cmd.addr == 6'h04;
    endsequence
    a_rd_answer: assert property (i_cmd.rd |=> o_rd_valid) else $error("read not answered");
    a_rd_quiet: assert property (!i_cmd.rd |=> !o_rd_valid) else $error("spurious read answer");
    a_maker_value: assert property (s_rd(6'h05) |=> o_rd_data == MAKER_ID) else $error("maker code wrong");
    a_rev_value: assert property (s_rd(6'h06) |=> o_rd_data == REVISION_ID) else $error("revision wrong");
    a_protect_sticky: assert property (o_io_cfg.repair_protect |=> o_io_cfg.repair_protect) else $error("protect lost");
    a_entry_refused: assert property (s_wr4 ##0 o_io_cfg.repair_protect && !o_repair_mode_entry |=> !o_repair_mode_entry)
        else $error("repair entry while protected");
    a_offset_reserved: assert property (s_wr4 ##0 i_cmd.data[6:5] == 2'h3 |=> $stable(o_thermal_offset))
        else $error("reserved offset stored");
    a_rate_tracks: assert property ((i_sensor_rate != o_refresh_rate) ##1 $stable(i_sensor_rate)
        |-> ##[0:1] (o_refresh_rate == i_sensor_rate && o_temp_update_flag)) else $error("rate or flag stale");
    a_flag_clear: assert property (s_rd(6'h04) ##0 i_sensor_rate == o_refresh_rate |=> !o_temp_update_flag)
        else $error("flag not cleared");
endmodule
`default_nettype wire

/* File: tb/dmr36_ctrl_model.sv */
// memory controller model issuing mode register writes and reads
// assumes the bench calls its tasks; commands launch 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dmr36_ctrl_model (
    input wire logic i_ref_clk,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    output var dmr36_pkg::dmr36_cmd_t o_cmd
);
    initial o_cmd = '0;
    // idle bus shows inverted leftovers so stale values never look valid
    task automatic idle();
        o_cmd = {2'b00, ~o_cmd.addr, ~o_cmd.data};
    endtask
    // callers keep pull-up point equal per channel; the bench also writes reserved codes to check they are refused
    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) #1;
        o_cmd = {2'b10, a, d};
        @(posedge i_ref_clk) #1;
        idle();
    endtask
    // codes 000 and 111 are only reported, the bench treats them as out of range
    task automatic mrr(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_ref_clk) #1;
        o_cmd = {2'b01, a, 8'h00};
        @(posedge i_ref_clk) #1;
        idle();
        ok = 1'b0;
        for (int n = 0; n < 4; n++) begin
            if (i_rd_valid === 1'b1) begin
                d = i_rd_data;
                ok = 1'b1;
                break;
            end
            @(posedge i_ref_clk) #1;
        end
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the mode register bank
// assumes the controller model drives all commands
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wsel = 1'b0;
    logic osel = 1'b0;
    logic [2:0] sens = 3'h3;
    dmr36_pkg::dmr36_cmd_t cmd;
    dmr36_pkg::dmr36_io_cfg_t cfg;
    logic rdv, sra, ent, temp_update_flag;
    logic [7:0] rdd;
    logic [2:0] rate;
    logic [1:0] ofs;
    int miscompares = 0;
    int cmp_count = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    dmr36_mode_regs dmr36_mode_regs_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd(cmd),
        .i_write_set_point_sel(wsel), .i_operating_set_point_sel(osel), .i_sensor_rate(sens),
        .o_rd_valid(rdv), .o_rd_data(rdd), .o_io_cfg(cfg), .o_refresh_rate(rate),
        .o_self_refresh_abort_en(sra), .o_repair_mode_entry(ent), .o_thermal_offset(ofs), .o_temp_update_flag(temp_update_flag));
    dmr36_ctrl_model dmr36_ctrl_model_i (.i_ref_clk(i_ref_clk), .i_rd_valid(rdv), .i_rd_data(rdd), .o_cmd(cmd));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a read that never answers leaves d unknown, counts a mismatch and ends the run
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        dmr36_ctrl_model_i.mrr(a, d, ok);
        chk(d, exp);
        if (!ok) wrap_up();
    endtask
    initial begin
        repeat (4) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        rd(6'h03, 8'h31);
        chk(cfg, 8'h31);
        rd(6'h04, 8'h03);
        rd(6'h05, 8'h5a);
        rd(6'h06, 8'ha5);
        rd(6'h07, 8'h00);
        $display("test reset values done");
        wsel = 1'b1;
        dmr36_ctrl_model_i.mrw(6'h03, 8'hd2);
        rd(6'h03, 8'hd2);
        chk(cfg, 8'h31);
        osel = 1'b1;
        #1 chk(cfg, 8'hd2);
        dmr36_ctrl_model_i.mrw(6'h03, 8'h3a);
        rd(6'h03, 8'h12);
        wsel = 1'b0;
        rd(6'h03, 8'h31);
        $display("test set points done");
        dmr36_ctrl_model_i.mrw(6'h04, 8'hff);
        rd(6'h04, 8'h1b);
        chk({7'h00, sra}, 8'h01);
        for (int k = 0; k < 3; k++) begin
            dmr36_ctrl_model_i.mrw(6'h04, {1'b0, k[1:0], 5'h00});
            rd(6'h04, {1'b0, k[1:0], 5'h03});
        end
        chk({6'h00, ofs}, 8'h02);
        $display("test refresh writes done");
        wsel = 1'b1;
        dmr36_ctrl_model_i.mrw(6'h03, 8'h16);
        dmr36_ctrl_model_i.mrw(6'h03, 8'h12);
        rd(6'h03, 8'h16);
        dmr36_ctrl_model_i.mrw(6'h04, 8'h10);
        rd(6'h04, 8'h03);
        chk({7'h00, ent}, 8'h00);
        $display("test repair protection done");
        sens = 3'h6;
        repeat (3) @(posedge i_ref_clk);
        chk({5'h00, rate}, 8'h06);
        chk({7'h00, temp_update_flag}, 8'h01);
        rd(6'h04, 8'h86);
        rd(6'h04, 8'h06);
        sens = 3'h1;
        rd(6'h04, 8'h81);
        $display("test temperature done");
        wrap_up();
    end
endmodule
bind dmr36_mode_regs dmr36_monitor #(.MAKER_ID(MAKER_ID), .REVISION_ID(REVISION_ID)) dmr36_monitor_i (
    .i_ref_clk, .i_rst, .i_cmd, .i_sensor_rate, .o_rd_valid, .o_rd_data, .o_io_cfg,
    .o_refresh_rate, .o_repair_mode_entry, .o_thermal_offset, .o_temp_update_flag);
`default_nettype wire
